// ---- qpot_params.svh ----
/*
  Timing counts, field positions and reset values shared by both ends of the
  quad potentiometer two-wire link.
  Assumes a 250 MHz system clock on both ends.
*/
`ifndef QPOT_PARAMS_SVH
`define QPOT_PARAMS_SVH

`define QPOT_SYS_CLK_PERIOD_NS 4
`define QPOT_NV_WRITE_TIME_US 5000
`define QPOT_NV_WRITE_CYCLES ((`QPOT_NV_WRITE_TIME_US * 1000) / `QPOT_SYS_CLK_PERIOD_NS)
`define QPOT_HALF_BIT_DIV 20
`define QPOT_TYPE_ID_DEFAULT 4'h3
`define QPOT_OP_LSB 4
`define QPOT_POT_LSB 2
`define QPOT_REG_LSB 0
`define QPOT_OP_RD_WIPER 4'h9
`define QPOT_OP_WR_WIPER 4'ha
`define QPOT_OP_RD_STORED 4'hb
`define QPOT_OP_WR_STORED 4'hc
`define QPOT_OP_XFR_TO_WIPER 4'hd
`define QPOT_OP_XFR_TO_STORED 4'he
`define QPOT_OP_GXFR_TO_WIPER 4'h1
`define QPOT_OP_GXFR_TO_STORED 4'h8
`define QPOT_WIPER_RESET 6'h00

`endif

// ---- qpot_pkg.sv ----
/*
  Types shared by both ends of the quad potentiometer link.
  Assumes qpot_params.svh is compiled with it.
*/
`default_nettype none

package qpot_pkg;

  typedef logic [5:0] wiper_t;
  typedef logic [7:0] byte_t;

endpackage

`default_nettype wire

// ---- qpot_link_if.sv ----
/*
  Two-wire link between the bus master and the potentiometer slave.
  Resolves the open-drain data wire from the two enables itself.
*/
`default_nettype none

interface qpot_link_if;
  logic scl;
  logic sda;
  logic m_sda_oe_n;
  logic s_sda_oe_n;

  // Open-drain wired AND with a pull-up: low wins when either enable is low.
  assign sda = m_sda_oe_n & s_sda_oe_n;

  modport master (output scl, output m_sda_oe_n, input sda);
  modport slave (input scl, input sda, output s_sda_oe_n);
endinterface

`default_nettype wire

// ---- quad_pot_serial_slave.sv ----
/*
  Slave end of the quad potentiometer two-wire link: framing, address match,
  command decode, wiper and stored registers, tap decode and write lockout.
  Assumes the master drives the clock line and obeys the bus conventions.
*/
// Notes on behaviour
// - Data line only pulled low or released.
// - Low address bits come from straps.
// - Master starts transfers and makes clock.
// - Data changes only while clock low.
// - Start is data falling, clock high.
// - Ignore everything until a start.
// - Stop is data rising, clock high.
// - Transmitter releases data after eight bits.
// - Receiver holds data low on ninth.
// - Ack address, command and data byte.
// - Exactly one tap switch per array.
// - Six wiper bits decode one-hot to 64.
// - Wiper written directly or from stored.
// - Address is type nibble then straps.
// - All four strap bits must match.
// - Stop after nonvolatile write starts lockout.
// - Write cycle lasts about five milliseconds.
// - No address ack while writing.
// - Master polls with address until ack.
// - Command is op, pot, stored register.
// - Wiper to stored copy is nonvolatile.
`include "qpot_params.svh"
`default_nettype none

module quad_pot_serial_slave
  import qpot_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = `QPOT_NV_WRITE_CYCLES,
  parameter logic [3:0] TYPE_ID = `QPOT_TYPE_ID_DEFAULT // Arbitrary value.
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  qpot_link_if.slave link,
  input wire logic [3:0] i_address_strap_inputs,
  output logic [63:0] o_tap_sel [4],
  output logic o_busy
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_DATA_RX = 3'b011,
    ST_DATA_TX = 3'b100,
    ST_IGNORE = 3'b101
  } slv_state_t;

  // ----------------------------------------------------------------------
  // Pin synchronisers and condition detection
  // ----------------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;

  // Two flops per pin, then a history flop for edge finding.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {link.scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {link.sda, sda_m_q, sda_s_q};
    end
  end

  // Strap pins pass two flops like every other pin before the compare reads them.
  logic [3:0] strap_m_q, strap_s_q;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) {strap_m_q, strap_s_q} <= 8'h00;
    else {strap_m_q, strap_s_q} <= {i_address_strap_inputs, strap_m_q};
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_det = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
  wire stop_det = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;

  // ----------------------------------------------------------------------
  // Byte framing state
  // ----------------------------------------------------------------------
  slv_state_t state_q, state_d;
  logic [3:0] bit_cnt_q;
  byte_t shift_q, cmd_q, tx_q;
  logic ack_phase_q, drive_low_q, nv_pending_q;
  logic [31:0] nv_cnt_q;
  wiper_t wiper_q [4];
  wiper_t stored_q [4][4];

  wire byte_done = scl_rise & (bit_cnt_q == 4'h7) & ~ack_phase_q;
  wire byte_t rx_byte = {shift_q[6:0], sda_s_q};
  wire [3:0] op = cmd_q[`QPOT_OP_LSB +: 4];
  wire [1:0] pot = cmd_q[`QPOT_POT_LSB +: 2];
  wire [1:0] sreg = cmd_q[`QPOT_REG_LSB +: 2];
  wire [3:0] rx_op = rx_byte[`QPOT_OP_LSB +: 4];
  wire [1:0] rx_pot = rx_byte[`QPOT_POT_LSB +: 2];
  wire [1:0] rx_sreg = rx_byte[`QPOT_REG_LSB +: 2];
  wire addr_hit = (rx_byte == {TYPE_ID, strap_s_q});
  wire three_byte = (rx_op == `QPOT_OP_RD_WIPER) | (rx_op == `QPOT_OP_WR_WIPER) |
                    (rx_op == `QPOT_OP_RD_STORED) | (rx_op == `QPOT_OP_WR_STORED);
  wire is_read = (rx_op == `QPOT_OP_RD_WIPER) | (rx_op == `QPOT_OP_RD_STORED);
  wire cmd_known = three_byte | (rx_op == `QPOT_OP_XFR_TO_WIPER) |
                   (rx_op == `QPOT_OP_XFR_TO_STORED) |
                   (rx_op == `QPOT_OP_GXFR_TO_WIPER) |
                   (rx_op == `QPOT_OP_GXFR_TO_STORED);
  wire nv_cmd = (op == `QPOT_OP_WR_STORED) | (op == `QPOT_OP_XFR_TO_STORED) |
                (op == `QPOT_OP_GXFR_TO_STORED);
  wire busy = nv_cnt_q != 32'h0;
  // which received bytes earn an acknowledge
  wire give_ack = (state_q == ST_ADDR) ? (addr_hit & ~busy) :
                  (state_q == ST_CMD) ? cmd_known : (state_q == ST_DATA_RX);

  // Next state on each received byte.
  always_comb begin
    state_d = state_q;
    if (byte_done) begin
      unique case (state_q)
        ST_ADDR: state_d = give_ack ? ST_CMD : ST_IGNORE;
        ST_CMD: state_d = ~cmd_known ? ST_IGNORE :
                          ~three_byte ? ST_IGNORE : (is_read ? ST_DATA_TX : ST_DATA_RX);
        ST_DATA_RX: state_d = ST_IGNORE;
        ST_DATA_TX: state_d = ST_IGNORE;
        ST_IDLE: state_d = ST_IDLE;
        ST_IGNORE: state_d = ST_IGNORE;
      endcase
    end
  end

  // framing with start and stop override
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_phase_q <= 1'b0;
    end else if (start_det) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      ack_phase_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (scl_rise & ~ack_phase_q) begin
        shift_q <= rx_byte;
        bit_cnt_q <= (bit_cnt_q == 4'h7) ? 4'h0 : bit_cnt_q + 4'h1;
      end
      if (byte_done) begin
        ack_phase_q <= 1'b1;
        state_q <= state_d;
      end else if (scl_rise & ack_phase_q) begin
        ack_phase_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data line driver
  // ----------------------------------------------------------------------
  logic ack_arm_q, tx_arm_q;
  logic [2:0] tx_bit_q;

  // change drive on clock falls; a start or stop releases it
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_arm_q <= 1'b0;
      tx_arm_q <= 1'b0;
      tx_bit_q <= 3'h7;
      drive_low_q <= 1'b0;
    end else if (start_det | stop_det) begin
      ack_arm_q <= 1'b0;
      tx_arm_q <= 1'b0;
      drive_low_q <= 1'b0;
    end else begin
      if (byte_done) begin
        ack_arm_q <= give_ack & (state_q != ST_DATA_TX);
        tx_arm_q <= (state_d == ST_DATA_TX) & (state_q == ST_CMD);
      end
      if (scl_fall) begin
        if (ack_arm_q) begin
          drive_low_q <= 1'b1;
          ack_arm_q <= 1'b0;
        end else if (tx_arm_q & ~ack_phase_q) begin
          drive_low_q <= ~tx_q[tx_bit_q];
          tx_bit_q <= tx_bit_q - 3'h1;
          tx_arm_q <= tx_bit_q != 3'h0;
        end else begin
          drive_low_q <= 1'b0;
          tx_bit_q <= 3'h7;
        end
      end
    end
  end

  // open drain, enable low pulls the line
  assign link.s_sda_oe_n = ~drive_low_q;

  // ----------------------------------------------------------------------
  // Registers, command execution and write lockout
  // ----------------------------------------------------------------------
  // Command and read data capture.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cmd_q <= 8'h00;
      tx_q <= 8'h00;
    end else if (byte_done & (state_q == ST_CMD)) begin
      cmd_q <= rx_byte;
      tx_q <= {2'b00, (rx_op == `QPOT_OP_RD_WIPER) ? wiper_q[rx_pot] : stored_q[rx_pot][rx_sreg]};
    end
  end

  // register updates from host and transfers
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int p = 0; p < 4; p++) begin
        wiper_q[p] <= `QPOT_WIPER_RESET;
        for (int r = 0; r < 4; r++) stored_q[p][r] <= `QPOT_WIPER_RESET;
      end
    end else if (byte_done & (state_q == ST_CMD) & cmd_known & ~three_byte) begin
      for (int p = 0; p < 4; p++) begin
        if (rx_op == `QPOT_OP_GXFR_TO_WIPER) wiper_q[p] <= stored_q[p][rx_sreg];
        if (rx_op == `QPOT_OP_GXFR_TO_STORED) stored_q[p][rx_sreg] <= wiper_q[p];
      end
      if (rx_op == `QPOT_OP_XFR_TO_WIPER) wiper_q[rx_pot] <= stored_q[rx_pot][rx_sreg];
      if (rx_op == `QPOT_OP_XFR_TO_STORED) stored_q[rx_pot][rx_sreg] <= wiper_q[rx_pot];
    end else if (byte_done & (state_q == ST_DATA_RX)) begin
      if (op == `QPOT_OP_WR_WIPER) wiper_q[pot] <= rx_byte[5:0];
      if (op == `QPOT_OP_WR_STORED) stored_q[pot][sreg] <= rx_byte[5:0];
    end
  end

  // lockout timer started by stop after a write
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      nv_pending_q <= 1'b0;
      nv_cnt_q <= 32'h0;
    end else begin
      if (start_det) begin
        nv_pending_q <= 1'b0;
      end else if (byte_done & (state_q == ST_CMD)) begin
        nv_pending_q <= 1'b0;
      end else if (ack_phase_q & scl_rise & drive_low_q & (state_q == ST_IGNORE)) begin
        // Only a final byte that this end acknowledged arms the write cycle.
        nv_pending_q <= nv_cmd;
      end
      if (stop_det & nv_pending_q) begin
        nv_cnt_q <= NV_WRITE_CYCLES[31:0];
        nv_pending_q <= 1'b0;
      end else if (busy) begin
        nv_cnt_q <= nv_cnt_q - 32'h1;
      end
    end
  end

  assign o_busy = busy;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int p = 0; p < 4; p++) o_tap_sel[p] <= 64'h1;
    end else begin
      for (int p = 0; p < 4; p++) o_tap_sel[p] <= 64'h1 << wiper_q[p];
    end
  end

endmodule

`default_nettype wire

// ---- quad_pot_bus_master.sv ----
/*
  Master end of the quad potentiometer link: sends a start, address,
  command, optional data byte and stop; reads back one byte.
  Assumes a slave with open-drain data output on the other end.
*/
`include "qpot_params.svh"
`default_nettype none

module quad_pot_bus_master
  import qpot_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  qpot_link_if.master link,
  input wire logic i_go,
  input wire logic [1:0] i_nbytes,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_cmd,
  input wire logic [7:0] i_wdata,
  input wire logic i_read,
  output logic o_ready,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata
);

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BITS = 3'b010,
    M_STOP = 3'b011,
    M_END = 3'b100
  } mst_state_t;

  mst_state_t state_q;
  logic [5:0] div_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [1:0] idx_q;
  logic scl_q, sda_q, nack_q, done_q;
  logic [7:0] rd_q;
  logic sda_m_q, sda_s_q;

  // Quarter-bit enable from the divider.
  wire tick = div_q == 6'(`QPOT_HALF_BIT_DIV - 1);
  wire byte_t cur = (idx_q == 2'd0) ? i_addr : (idx_q == 2'd1) ? i_cmd : i_wdata;
  wire rx_byte = i_read & (idx_q == 2'd2);

  // Two flops on the returning data line.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) {sda_m_q, sda_s_q} <= 2'b11;
    else {sda_m_q, sda_s_q} <= {link.sda, sda_m_q};
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= M_IDLE;
      div_q <= 6'h0;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      div_q <= tick ? 6'h0 : div_q + 6'h1;
      if (state_q == M_IDLE) begin
        if (i_go) begin
          state_q <= M_START;
          nack_q <= 1'b0;
          idx_q <= 2'h0;
          bit_q <= 4'h0;
          phase_q <= 2'h0;
        end
      end else if (tick) begin
        unique case (state_q)
          M_START: begin
            sda_q <= 1'b0;
            state_q <= M_BITS;
          end
          M_BITS: begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h0) begin
              scl_q <= 1'b0;
            end else if (phase_q == 2'h1) begin
              // Released on the ninth bit and for every bit of a read byte.
              sda_q <= (bit_q == 4'h8) | rx_byte | cur[3'(7 - bit_q)];
            end else if (phase_q == 2'h2) begin
              scl_q <= 1'b1;
            end else begin
              // acknowledge sampled on the ninth pulse
              if (bit_q == 4'h8) begin
                if (!rx_byte && sda_s_q) nack_q <= 1'b1;
                bit_q <= 4'h0;
                if (idx_q == i_nbytes - 2'h1 || (!rx_byte && sda_s_q)) state_q <= M_STOP;
                idx_q <= idx_q + 2'h1;
              end else begin
                if (rx_byte) rd_q <= {rd_q[6:0], sda_s_q};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          M_STOP: begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h0) scl_q <= 1'b0;
            else if (phase_q == 2'h1) sda_q <= 1'b0;
            else if (phase_q == 2'h2) scl_q <= 1'b1;
            else begin
              sda_q <= 1'b1;
              state_q <= M_END;
            end
          end
          M_END: begin
            done_q <= 1'b1;
            state_q <= M_IDLE;
          end
          M_IDLE: state_q <= M_IDLE;
          default: state_q <= M_IDLE;
        endcase
      end
    end
  end

  assign link.scl = scl_q;
  assign link.m_sda_oe_n = sda_q;
  assign o_ready = state_q == M_IDLE;
  assign o_done = done_q;
  assign o_nack = nack_q;
  assign o_rdata = rd_q;

endmodule

`default_nettype wire

// ---- qpot_link_props.sv ----
/*
  Checker for the two-wire link that joins the master and slave ends.
  Assumes the bench instantiates it beside the link interface.
*/
`default_nettype none

module qpot_link_props #(
  parameter int NV_WRITE_CYCLES = 200
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n,
  input wire logic o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  // ----------------------------------------
  // Lockout length counter
  // ----------------------------------------
  // Counts the cycles of one write lockout.
  int busy_cnt_q;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) busy_cnt_q <= 0;
    else busy_cnt_q <= o_busy ? busy_cnt_q + 1 : 0;
  end

  // ----------------------------------------
  // Link properties
  // ----------------------------------------
  // open drain pull
  drain_only_low_a: assert property ($rose(scl) && !s_sda_oe_n |-> m_sda_oe_n)
    else $error("slave and master both pulled data at a clock rise");
  slave_change_low_a: assert property ($changed(s_sda_oe_n) |-> !scl)
    else $error("slave changed data while clock high");
  ack_holds_a: assert property ($fell(s_sda_oe_n) |-> !s_sda_oe_n [*8])
    else $error("slave pull of data line too short");
  busy_no_ack_a: assert property (o_busy |-> s_sda_oe_n)
    else $error("slave drove data during lockout");
  busy_after_stop_a: assert property ($rose(o_busy) |-> scl && sda)
    else $error("lockout began while the bus was not idle");
  busy_length_a: assert property (
    $fell(o_busy) |-> busy_cnt_q inside {[NV_WRITE_CYCLES - 4 : NV_WRITE_CYCLES + 4]})
    else $error("lockout length wrong");
  scl_half_bit_a: assert property ($changed(scl) |=> $stable(scl) [*8])
    else $error("clock half period too short");
  start_then_clock_a: assert property ($fell(sda) && scl |-> ##[1:60] !scl)
    else $error("no clocking after start");
  stop_idle_a: assert property ($rose(sda) && scl |=> scl [*8])
    else $error("clock moved right after stop");

  // Main scenarios reached.
  ack_seen_c: cover property ($fell(s_sda_oe_n));
  lock_start_c: cover property ($rose(o_busy));
  lock_end_c: cover property ($fell(o_busy));
endmodule

`default_nettype wire

// ---- testbench.sv ----
/*
  Self-checking bench: master and slave ends joined by one link.
  Assumes the design files and the link checker are compiled first.
*/
`include "qpot_params.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import qpot_pkg::*;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int NV_CYC = 1500;
  localparam logic [3:0] STRAPS = 4'h6;
  localparam byte_t ADDR = {`QPOT_TYPE_ID_DEFAULT, STRAPS};
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic go = 1'b0;
  logic [1:0] nbytes = 2'h2;
  byte_t addr = 8'h00;
  byte_t cmd = 8'h00;
  byte_t wdata = 8'h00;
  logic rd = 1'b0;
  logic ready, done, nack, busy;
  byte_t rdata;
  logic [63:0] tap [4];
  int mismatches = 0;
  int total_checks = 0;

  // Free-running 250 MHz clock.
  always #2 i_sys_clk = ~i_sys_clk;

  qpot_link_if qpot_link_if_inst();
  quad_pot_serial_slave #(.NV_WRITE_CYCLES(NV_CYC)) quad_pot_serial_slave_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .link(qpot_link_if_inst),
    .i_address_strap_inputs(STRAPS), .o_tap_sel(tap), .o_busy(busy));
  quad_pot_bus_master quad_pot_bus_master_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .link(qpot_link_if_inst), .i_go(go),
    .i_nbytes(nbytes), .i_addr(addr), .i_cmd(cmd), .i_wdata(wdata), .i_read(rd),
    .o_ready(ready), .o_done(done), .o_nack(nack), .o_rdata(rdata));
  qpot_link_props #(.NV_WRITE_CYCLES(NV_CYC)) qpot_link_props_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .scl(qpot_link_if_inst.scl),
    .sda(qpot_link_if_inst.sda), .m_sda_oe_n(qpot_link_if_inst.m_sda_oe_n),
    .s_sda_oe_n(qpot_link_if_inst.s_sda_oe_n), .o_busy(busy));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Runs one framed transfer through the master and waits for its end.
  task automatic xfer(input byte_t a, input byte_t c, input byte_t d, input logic [1:0] n,
                      input logic r);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    while (ready !== 1'b1 && k < 5000) begin
      @(posedge i_sys_clk);
      k++;
    end
    addr <= a;
    cmd <= c;
    wdata <= d;
    nbytes <= n;
    rd <= r;
    go <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      @(posedge i_sys_clk);
      k++;
    end
    chk("transfer done", 64'h1, {63'h0, done});
    chk("master idle", 64'h1, {63'h0, ready});
  endtask

  // Waits out a write lockout by repeated address polling.
  task automatic poll_until_ack();
    int tries;
    tries = 0;
    repeat (8) @(posedge i_sys_clk);
    chk("lockout started", 64'h1, {63'h0, busy});
    do begin
      xfer(ADDR, {`QPOT_OP_RD_WIPER, 4'h0}, 8'h00, 2'h3, 1'b1);
      tries++;
    end while (nack === 1'b1 && tries < 20);
    chk("polls refused", 64'h1, {63'h0, tries > 1});
    chk("poll answered", 64'h0, {63'h0, nack});
    chk("lockout over", 64'h0, {63'h0, busy});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset leaves every array on tap zero.
  task automatic s_reset();
    for (int i = 0; i < 4; i++) begin
      chk("reset tap", 64'h1, tap[i]);
    end
    chk("reset lockout", 64'h0, {63'h0, busy});
  endtask

  // Direct wiper write and read back on pot one.
  task automatic s_wiper();
    xfer(ADDR, {`QPOT_OP_WR_WIPER, 4'h4}, 8'h2a, 2'h3, 1'b0);
    chk("write acked", 64'h0, {63'h0, nack});
    chk("tap pot1", 64'h1 << 42, tap[1]);
    chk("tap pot0", 64'h1, tap[0]);
    xfer(ADDR, {`QPOT_OP_RD_WIPER, 4'h4}, 8'h00, 2'h3, 1'b1);
    chk("wiper read", 64'h2a, {56'h0, rdata});
  endtask

  // Wrong type nibble or strap bit is ignored.
  task automatic s_bad_addr();
    byte_t bad [2];
    bad = '{ADDR ^ 8'h01, ADDR ^ 8'h80};
    for (int i = 0; i < 2; i++) begin
      xfer(bad[i], {`QPOT_OP_WR_WIPER, 4'h4}, 8'h05, 2'h3, 1'b0);
      chk("mismatch refused", 64'h1, {63'h0, nack});
      chk("tap unchanged", 64'h1 << 42, tap[1]);
    end
  endtask

  // Stored write, lockout, read back and transfer to wiper.
  task automatic s_store();
    xfer(ADDR, {`QPOT_OP_WR_STORED, 4'h6}, 8'h15, 2'h3, 1'b0);
    chk("store acked", 64'h0, {63'h0, nack});
    poll_until_ack();
    xfer(ADDR, {`QPOT_OP_RD_STORED, 4'h6}, 8'h00, 2'h3, 1'b1);
    chk("stored read", 64'h15, {56'h0, rdata});
    xfer(ADDR, {`QPOT_OP_XFR_TO_WIPER, 4'h6}, 8'h00, 2'h2, 1'b0);
    chk("stored to wiper", 64'h1 << 21, tap[1]);
  endtask

  // Top tap, then copy wiper to stored, which locks out.
  task automatic s_copy();
    xfer(ADDR, {`QPOT_OP_WR_WIPER, 4'hc}, 8'h3f, 2'h3, 1'b0);
    chk("top tap", 64'h1 << 63, tap[3]);
    xfer(ADDR, {`QPOT_OP_XFR_TO_STORED, 4'hf}, 8'h00, 2'h2, 1'b0);
    chk("copy acked", 64'h0, {63'h0, nack});
    poll_until_ack();
    xfer(ADDR, {`QPOT_OP_RD_STORED, 4'hf}, 8'h00, 2'h3, 1'b1);
    chk("copied value", 64'h3f, {56'h0, rdata});
  endtask

  // Global transfers move every pot at once; an unknown code is refused.
  task automatic s_global();
    xfer(ADDR, {`QPOT_OP_GXFR_TO_WIPER, 4'h3}, 8'h00, 2'h2, 1'b0);
    chk("global acked", 64'h0, {63'h0, nack});
    chk("global pot1", 64'h1, tap[1]);
    chk("global pot3", 64'h1 << 63, tap[3]);
    xfer(ADDR, {`QPOT_OP_GXFR_TO_STORED, 4'h0}, 8'h00, 2'h2, 1'b0);
    poll_until_ack();
    xfer(ADDR, {`QPOT_OP_RD_STORED, 4'hc}, 8'h00, 2'h3, 1'b1);
    chk("global stored", 64'h3f, {56'h0, rdata});
    xfer(ADDR, 8'h20, 8'h00, 2'h2, 1'b0);
    chk("unknown refused", 64'h1, {63'h0, nack});
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  // Releases reset after four cycles and runs every scenario.
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    s_reset();
    s_wiper();
    s_bad_addr();
    s_store();
    s_copy();
    s_global();
    test_done();
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule

`default_nettype wire
